// *** hw/output_terminal_function_select.v ***
// Decided for this implementation: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "output_terminal_function_select_map.vh"

// Function
// - mode 0 pulse, 1 switch, default switch
// - pulse rate never above 100 kHz
// - two independent codes 0..18, default 0
// - code 0 never asserts
// - code 1 follows running state
// - code 2 needs stable, no fault, ready
// - code 3 fault except continue action
// - code 4 also excludes undervoltage
// - code 5 any failure
// - code 6 undervoltage
// - codes 7..11 route detection flags
// - code 12 zero speed, off stopped
// - zero speed two, on when stopped
// - upper limit reached selection
// - lower limit, off or on stopped
// - current one and two flags
module output_terminal_function_select (
    // clock, enable, reset
    input wire clk,
    input wire ce,
    input wire rst_b,
    // axi4-lite write address
    input wire [`AXI_ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    // axi4-lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // axi4-lite write response
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    // axi4-lite read address
    input wire [`AXI_ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    // axi4-lite read data
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready,
    // drive state
    input wire drive_running,
    input wire out_freq_zero,
    input wire main_circuit_stable,
    input wire ready_state,
    // fault conditions
    input wire fault_active,
    input wire fault_continue_action,
    input wire fault_is_undervoltage,
    input wire undervoltage,
    // detection flags from elsewhere
    input wire frequency_level_detect_one,
    input wire frequency_level_detect_two,
    input wire freq_reached,
    input wire freq1_reached,
    input wire freq2_reached,
    input wire upper_limit_reached,
    input wire lower_limit_reached,
    input wire current1_reached,
    input wire current2_reached,
    // terminals
    output wire first_output_terminal,
    output wire relay_output
);

// ----------------------------------------
// reset synchroniser
// ----------------------------------------
reg rst_meta_q; // first stage, read only by second
reg rst_n_q; // released reset used everywhere

// release through two flops so deassertion is clean
always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        rst_meta_q <= 1'b0;
        rst_n_q <= 1'b0;
    end else begin
        rst_meta_q <= 1'b1;
        rst_n_q <= rst_meta_q;
    end
end

// ----------------------------------------
// registers and bus state
// ----------------------------------------
reg [15:0] mode_sel_q; // first output mode
reg [15:0] first_func_q; // first output code
reg [15:0] relay_func_q; // relay code
reg [15:0] half_period_q; // pulse half period in cycles
reg awready_q; // address slot free
reg wready_q; // data slot free
reg bvalid_q; // write answer pending
reg [1:0] bresp_q; // write answer code
reg [`AXI_ADDR_W-1:0] aw_addr_q; // held write address
reg [31:0] w_data_q; // held write data
reg [3:0] w_strb_q; // held byte enables
reg arready_q; // read slot free
reg rvalid_q; // read answer pending
reg [31:0] rdata_q; // read answer data
reg [1:0] rresp_q; // read answer code
reg first_out_q; // first terminal level
reg relay_out_q; // relay level

wire wr_fire; // both halves held, no answer out
wire [`ST_W-1:0] status_vec; // packed drive status
wire first_sel; // first terminal decoded condition
wire relay_sel; // relay decoded condition
wire pulse_mode; // first terminal runs pulse train
wire pulse_level; // pulse generator output

// ----------------------------------------
// byte lane merge
// ----------------------------------------
// only the two low lanes exist; upper lanes are dropped
function [15:0] merge16;
    input [15:0] old_v;
    input [31:0] new_v;
    input [3:0] strb;
    begin
        merge16[7:0] = strb[0] ? new_v[7:0] : old_v[7:0];
        merge16[15:8] = strb[1] ? new_v[15:8] : old_v[15:8];
    end
endfunction

// ----------------------------------------
// write channel
// ----------------------------------------
// a write happens once both address and data are held
assign wr_fire = ~awready_q & ~wready_q & ~bvalid_q;

// address and data taken in either order, one write at a time
always @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
        awready_q <= 1'b1;
        wready_q <= 1'b1;
        bvalid_q <= 1'b0;
        bresp_q <= `RESP_OKAY;
        aw_addr_q <= {`AXI_ADDR_W{1'b0}};
        w_data_q <= 32'h00000000;
        w_strb_q <= 4'h0;
    end else if (ce) begin
        // capture address
        if (s_axi_awvalid && awready_q) begin
            aw_addr_q <= s_axi_awaddr;
            awready_q <= 1'b0;
        end
        // capture data
        if (s_axi_wvalid && wready_q) begin
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
            wready_q <= 1'b0;
        end
        // raise answer once the write is done
        if (wr_fire) begin
            bvalid_q <= 1'b1;
            case ({aw_addr_q[`AXI_ADDR_W-1:2], 2'h0})
                `OFS_FIRST_OUTPUT_MODE_SELECT: bresp_q <= `RESP_OKAY;
                `OFS_FIRST_OUTPUT_FUNCTION_SELECT: bresp_q <= `RESP_OKAY;
                `OFS_RELAY_OUTPUT_FUNCTION_SELECT: bresp_q <= `RESP_OKAY;
                `OFS_PULSE_HALF_PERIOD: bresp_q <= `RESP_OKAY;
                // read-only or unmapped
                default: bresp_q <= `RESP_SLVERR;
            endcase
        end
        // answer accepted, reopen both slots
        if (bvalid_q && s_axi_bready) begin
            bvalid_q <= 1'b0;
            awready_q <= 1'b1;
            wready_q <= 1'b1;
        end
    end
end

// ----------------------------------------
// configuration registers
// ----------------------------------------
// software steers the terminals through these
always @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
        mode_sel_q <= `RST_FIRST_OUTPUT_MODE_SELECT;
        first_func_q <= `RST_FIRST_OUTPUT_FUNCTION_SELECT;
        relay_func_q <= `RST_RELAY_OUTPUT_FUNCTION_SELECT;
        half_period_q <= `RST_PULSE_HALF_PERIOD;
    end else if (ce && wr_fire) begin
        case ({aw_addr_q[`AXI_ADDR_W-1:2], 2'h0})
            `OFS_FIRST_OUTPUT_MODE_SELECT: begin
                mode_sel_q <= merge16(mode_sel_q, w_data_q, w_strb_q);
            end
            `OFS_FIRST_OUTPUT_FUNCTION_SELECT: begin
                first_func_q <= merge16(first_func_q, w_data_q, w_strb_q);
            end
            `OFS_RELAY_OUTPUT_FUNCTION_SELECT: begin
                relay_func_q <= merge16(relay_func_q, w_data_q, w_strb_q);
            end
            `OFS_PULSE_HALF_PERIOD: begin
                half_period_q <= merge16(half_period_q, w_data_q, w_strb_q);
            end
            // nothing stored elsewhere
            default: begin
                mode_sel_q <= mode_sel_q;
            end
        endcase
    end
end

// ----------------------------------------
// read channel
// ----------------------------------------
// data is sampled at the address edge, so status is one cycle old
always @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
        arready_q <= 1'b1;
        rvalid_q <= 1'b0;
        rdata_q <= 32'h00000000;
        rresp_q <= `RESP_OKAY;
    end else if (ce) begin
        if (s_axi_arvalid && arready_q) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rresp_q <= `RESP_OKAY;
            case ({s_axi_araddr[`AXI_ADDR_W-1:2], 2'h0})
                `OFS_FIRST_OUTPUT_MODE_SELECT: rdata_q <= {16'h0000, mode_sel_q};
                `OFS_FIRST_OUTPUT_FUNCTION_SELECT: rdata_q <= {16'h0000, first_func_q};
                `OFS_RELAY_OUTPUT_FUNCTION_SELECT: rdata_q <= {16'h0000, relay_func_q};
                `OFS_PULSE_HALF_PERIOD: rdata_q <= {16'h0000, half_period_q};
                // live terminal state
                `OFS_OUTPUT_STATUS: rdata_q <= {29'h00000000, pulse_mode, relay_out_q, first_out_q};
                // unmapped reads zero with error
                default: begin
                    rdata_q <= 32'h00000000;
                    rresp_q <= `RESP_SLVERR;
                end
            endcase
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
        end
    end
end

// ----------------------------------------
// status packing
// ----------------------------------------
// status comes from logic on this clock, so no synchroniser
assign status_vec[`ST_RUN] = drive_running;
assign status_vec[`ST_FREQ_ZERO] = out_freq_zero;
assign status_vec[`ST_MAIN_STABLE] = main_circuit_stable;
assign status_vec[`ST_READY_STATE] = ready_state;
assign status_vec[`ST_FAULT] = fault_active;
assign status_vec[`ST_FAULT_CONT] = fault_continue_action;
assign status_vec[`ST_UNDERVOLT] = undervoltage;
assign status_vec[`ST_FREQUENCY_LEVEL_DETECT_ONE] = frequency_level_detect_one;
assign status_vec[`ST_FREQUENCY_LEVEL_DETECT_TWO] = frequency_level_detect_two;
assign status_vec[`ST_FREQ_REACHED] = freq_reached;
assign status_vec[`ST_FREQ1_REACHED] = freq1_reached;
assign status_vec[`ST_FREQ2_REACHED] = freq2_reached;
assign status_vec[`ST_UPPER_LIMIT] = upper_limit_reached;
assign status_vec[`ST_LOWER_LIMIT] = lower_limit_reached;
assign status_vec[`ST_CURRENT1] = current1_reached;
assign status_vec[`ST_CURRENT2] = current2_reached;
assign status_vec[`ST_FAULT_IS_UV] = fault_is_undervoltage;

// ----------------------------------------
// function decoders
// ----------------------------------------
// first output terminal selection
function_code_decode u_first_decode (
    .code(first_func_q),
    .st(status_vec),
    .active(first_sel)
);

// relay selection
function_code_decode u_relay_decode (
    .code(relay_func_q),
    .st(status_vec),
    .active(relay_sel)
);

// ----------------------------------------
// pulse output
// ----------------------------------------
// value zero picks pulse when fitted
assign pulse_mode = (mode_sel_q == `MODE_PULSE) & `PULSE_OPTION_PRESENT;

// the train only runs in pulse mode to save toggling
pulse_output_gen u_pulse (
    .clk(clk),
    .ce(ce),
    .rst_n(rst_n_q),
    .run(pulse_mode),
    .half_period(half_period_q),
    .pulse_q(pulse_level)
);

// ----------------------------------------
// terminal drivers
// ----------------------------------------
// registered so the pins never glitch on code changes
always @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
        first_out_q <= 1'b0;
        relay_out_q <= 1'b0;
    end else if (ce) begin
        if (pulse_mode) begin
            first_out_q <= pulse_level;
        end else begin
            first_out_q <= first_sel;
        end
        relay_out_q <= relay_sel;
    end
end

// ----------------------------------------
// output assignments
// ----------------------------------------
assign s_axi_awready = awready_q;
assign s_axi_wready = wready_q;
assign s_axi_bresp = bresp_q;
assign s_axi_bvalid = bvalid_q;
assign s_axi_arready = arready_q;
assign s_axi_rdata = rdata_q;
assign s_axi_rresp = rresp_q;
assign s_axi_rvalid = rvalid_q;
assign first_output_terminal = first_out_q;
assign relay_output = relay_out_q;

endmodule // output_terminal_function_select

// *** hw/output_terminal_function_select_map.vh ***
`ifndef OUTPUT_TERMINAL_FUNCTION_SELECT_MAP_VH
`define OUTPUT_TERMINAL_FUNCTION_SELECT_MAP_VH

// ----------------------------------------
// clock and pulse timing
// ----------------------------------------
`define CLK_FREQ_HZ 20000000
`define PULSE_MAX_FREQ_HZ 100000
// least half period, rounded up to whole cycles
`define PULSE_MIN_HALF_CYCLES ((`CLK_FREQ_HZ + 2 * `PULSE_MAX_FREQ_HZ - 1) / (2 * `PULSE_MAX_FREQ_HZ))
// pulse output fitted to this unit (1 = present)
`define PULSE_OPTION_PRESENT 1'b1

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define AXI_ADDR_W 8
`define OFS_FIRST_OUTPUT_MODE_SELECT 8'h00
`define OFS_FIRST_OUTPUT_FUNCTION_SELECT 8'h04
`define OFS_RELAY_OUTPUT_FUNCTION_SELECT 8'h08
`define OFS_PULSE_HALF_PERIOD 8'h0C
`define OFS_OUTPUT_STATUS 8'h10

// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_FIRST_OUTPUT_MODE_SELECT 16'h0001
`define RST_FIRST_OUTPUT_FUNCTION_SELECT 16'h0000
`define RST_RELAY_OUTPUT_FUNCTION_SELECT 16'h0000
`define RST_PULSE_HALF_PERIOD 16'h0064

// ----------------------------------------
// mode and axi response codes
// ----------------------------------------
`define MODE_PULSE 16'h0000
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// ----------------------------------------
// status vector bit positions
// ----------------------------------------
`define ST_W 17
`define ST_RUN 0
`define ST_FREQ_ZERO 1
`define ST_MAIN_STABLE 2
`define ST_READY_STATE 3
`define ST_FAULT 4
`define ST_FAULT_CONT 5
`define ST_UNDERVOLT 6
`define ST_FREQUENCY_LEVEL_DETECT_ONE 7
`define ST_FREQUENCY_LEVEL_DETECT_TWO 8
`define ST_FREQ_REACHED 9
`define ST_FREQ1_REACHED 10
`define ST_FREQ2_REACHED 11
`define ST_UPPER_LIMIT 12
`define ST_LOWER_LIMIT 13
`define ST_CURRENT1 14
`define ST_CURRENT2 15
`define ST_FAULT_IS_UV 16

`endif

// *** hw/function_code_decode.v ***
`timescale 1ns/100ps
`include "output_terminal_function_select_map.vh"

module function_code_decode (
    // selection code
    input wire [15:0] code,
    // drive status flags
    input wire [`ST_W-1:0] st,
    // chosen condition
    output reg active
);

// ----------------------------------------
// code to condition mapping
// ----------------------------------------
// one decoder per terminal keeps the two selections independent
always @* begin
    active = 1'b0;
    case (code)
        16'h0000: active = 1'b0;
        16'h0001: active = st[`ST_RUN];
        16'h0002: active = st[`ST_MAIN_STABLE] & ~st[`ST_FAULT] & st[`ST_READY_STATE];
        16'h0003: active = st[`ST_FAULT] & ~st[`ST_FAULT_CONT];
        16'h0004: active = st[`ST_FAULT] & ~st[`ST_FAULT_CONT] & ~st[`ST_FAULT_IS_UV];
        16'h0005: active = st[`ST_FAULT];
        16'h0006: active = st[`ST_UNDERVOLT];
        16'h0007: active = st[`ST_FREQUENCY_LEVEL_DETECT_ONE];
        16'h0008: active = st[`ST_FREQUENCY_LEVEL_DETECT_TWO];
        16'h0009: active = st[`ST_FREQ_REACHED];
        16'h000A: active = st[`ST_FREQ1_REACHED];
        16'h000B: active = st[`ST_FREQ2_REACHED];
        16'h000C: active = st[`ST_RUN] & st[`ST_FREQ_ZERO];
        16'h000D: active = ~st[`ST_RUN] | st[`ST_FREQ_ZERO];
        16'h000E: active = st[`ST_UPPER_LIMIT];
        16'h000F: active = st[`ST_RUN] & st[`ST_LOWER_LIMIT];
        16'h0010: active = ~st[`ST_RUN] | st[`ST_LOWER_LIMIT];
        16'h0011: active = st[`ST_CURRENT1];
        16'h0012: active = st[`ST_CURRENT2];
        default: active = 1'b0;
    endcase
end

endmodule // function_code_decode

// *** hw/pulse_output_gen.v ***
`timescale 1ns/100ps
`include "output_terminal_function_select_map.vh"

module pulse_output_gen (
    // clock, enable, reset
    input wire clk,
    input wire ce,
    input wire rst_n,
    // control
    input wire run,
    input wire [15:0] half_period,
    // square wave
    output reg pulse_q
);

reg [15:0] cnt_q; // cycles into current half
wire [15:0] min_half; // fastest allowed half period
wire [15:0] half_eff; // clamped half period

// limit is a 32-bit count; it fits 16 bits, so keep the low half on purpose
localparam integer MIN_HALF_FULL = `PULSE_MIN_HALF_CYCLES;
assign min_half = MIN_HALF_FULL[15:0];
// clamp keeps rate at or below limit
assign half_eff = (half_period < min_half) ? min_half : half_period;

// ----------------------------------------
// half period counter
// ----------------------------------------
// a zero setting stops the train rather than running at the limit
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        cnt_q <= 16'h0000;
        pulse_q <= 1'b0;
    end else if (ce) begin
        if (!run || half_period == 16'h0000) begin
            // idle low
            cnt_q <= 16'h0000;
            pulse_q <= 1'b0;
        end else if (cnt_q >= half_eff - 16'h0001) begin
            cnt_q <= 16'h0000;
            pulse_q <= ~pulse_q;
        end else begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end
end

endmodule // pulse_output_gen

// *** testbench/output_terminal_function_select_checker.sv ***
`timescale 1ns/100ps
`include "output_terminal_function_select_map.vh"

module output_terminal_function_select_checker (
    // clock and reset
    input wire clk,
    input wire rst_b,
    // write side of the register bus
    input wire [`AXI_ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    // status conditions
    input wire drive_running,
    input wire out_freq_zero,
    input wire fault_active,
    input wire fault_continue_action,
    input wire undervoltage,
    // terminals
    input wire first_output_terminal,
    input wire relay_output
);
    // ----------------------------------------
    // shadow of the selection registers
    // ----------------------------------------
    logic [7:0] adr_q; // address of the write under way
    logic [15:0] dat_q; // low half of its data
    logic [15:0] md_q; // mode shadow
    logic [15:0] fc_q; // first terminal code shadow
    logic [15:0] rc_q; // relay code shadow
    logic chg_q; // a write landed last cycle
    wire ok = !chg_q; // skip the cycle where the code just moved

    // capture on handshakes, commit only on an okay response
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            adr_q <= 8'h00;
            dat_q <= 16'h0000;
            md_q <= 16'h0001;
            fc_q <= 16'h0000;
            rc_q <= 16'h0000;
            chg_q <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) adr_q <= s_axi_awaddr;
            if (s_axi_wvalid && s_axi_wready) dat_q <= s_axi_wdata[15:0];
            chg_q <= s_axi_bvalid && s_axi_bready;
            if (s_axi_bvalid && s_axi_bready && s_axi_bresp == `RESP_OKAY) begin
                if (adr_q == `OFS_FIRST_OUTPUT_MODE_SELECT) md_q <= dat_q;
                if (adr_q == `OFS_FIRST_OUTPUT_FUNCTION_SELECT) fc_q <= dat_q;
                if (adr_q == `OFS_RELAY_OUTPUT_FUNCTION_SELECT) rc_q <= dat_q;
            end
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    // ----------------------------------------
    // terminal decode against its cause
    // ----------------------------------------
    // code zero silent
    AST_CODE_ZERO: assert property (ok && rc_q == 16'h0000 |-> !relay_output)
        else $error("relay on with code zero");
    AST_RUN: assert property (ok && rc_q == 16'h0001 |-> relay_output == $past(drive_running))
        else $error("relay not following running");
    AST_FAULT_ONE: assert property (ok && rc_q == 16'h0003 |->
        relay_output == $past(fault_active && !fault_continue_action))
        else $error("fault output one wrong");
    AST_FAULT_ANY: assert property (ok && md_q != 16'h0000 && fc_q == 16'h0005 |->
        first_output_terminal == $past(fault_active))
        else $error("first terminal not following fault");
    AST_UNDERVOLT: assert property (ok && rc_q == 16'h0006 |-> relay_output == $past(undervoltage))
        else $error("relay not following undervoltage");
    AST_ZERO_ONE: assert property (ok && rc_q == 16'h000C |->
        relay_output == $past(drive_running && out_freq_zero))
        else $error("zero speed one wrong");
    AST_ZERO_TWO: assert property (ok && rc_q == 16'h000D |->
        relay_output == $past(!drive_running || out_freq_zero))
        else $error("zero speed two wrong");
    AST_UNUSED: assert property (ok && rc_q > 16'h0012 |-> !relay_output)
        else $error("relay on with unused code");

    // main scenarios reached
    cover property (ok && rc_q == 16'h000D && relay_output);
    cover property (s_axi_bvalid && s_axi_bresp == `RESP_SLVERR);
    cover property (md_q == 16'h0000 && $changed(first_output_terminal));
endmodule // output_terminal_function_select_checker

bind output_terminal_function_select output_terminal_function_select_checker chk (.*);

// *** testbench/terminal_reader.sv ***
`timescale 1ns/100ps

module terminal_reader (
    // clock and reset
    input wire clk,
    input wire rst_b,
    // watched terminal
    input wire pin,
    // cycles the pin held between its last two toggles
    output int half_q
);
    int cnt_q; // cycles since last toggle
    logic last_q; // previous level

    // measure run length, latch it at each toggle
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q <= 0;
            last_q <= 1'b0;
            half_q <= 0;
        end else begin
            last_q <= pin;
            if (pin !== last_q) begin
                half_q <= cnt_q;
                cnt_q <= 1;
            end else begin
                cnt_q <= cnt_q + 1;
            end
        end
    end
endmodule // terminal_reader

// *** testbench/output_terminal_function_select_tb_top.sv ***
`timescale 1ns/100ps
`include "output_terminal_function_select_map.vh"

module output_terminal_function_select_tb_top;
    // ----------------------------------------
    // stimulus and observed signals
    // ----------------------------------------
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic ce = 1'b1; // held on, freezing is not exercised
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [16:0] stv = 17'h00000; // status flags, bit order of the map header
    wire awready, wready, bvalid, arready, rvalid, first, relay;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    int half; // measured pulse half period
    int failures = 0;
    int checked = 0;
    int i;
    // code, status that asserts, status that does not, expected asserted level
    logic [15:0] codes [0:21] = '{16'h0, 16'h1, 16'h2, 16'h3, 16'h4, 16'h5, 16'h6, 16'h7, 16'h8, 16'h9,
        16'hA, 16'hB, 16'hC, 16'hD, 16'hE, 16'hF, 16'h10, 16'h11, 16'h12, 16'h13, 16'h2A, 16'hFFFF};
    logic [16:0] v_on [0:21] = '{17'h1FFFF, 17'h3, 17'hC, 17'h10, 17'h10, 17'h30, 17'h40, 17'h80,
        17'h100, 17'h200, 17'h400, 17'h800, 17'h3, 17'h0, 17'h1000, 17'h2001, 17'h2000, 17'h4000,
        17'h8000, 17'h1FFFF, 17'h1FFFF, 17'h1FFFF};
    logic [16:0] v_off [0:21] = '{17'h0, 17'h1FFFE, 17'h1C, 17'h30, 17'h10010, 17'h1FFEF, 17'h1FFBF,
        17'h1FF7F, 17'h1FEFF, 17'h1FDFF, 17'h1FBFF, 17'h1F7FF, 17'h2, 17'h1, 17'h1EFFF, 17'h2000,
        17'h1, 17'h1BFFF, 17'h17FFF, 17'h0, 17'h0, 17'h0};
    logic [21:0] e_on = 22'h07FFFE;

    initial forever #25 clk = ~clk;

    output_terminal_function_select DUT (
        .clk(clk), .ce(ce), .rst_b(rst_b), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .drive_running(stv[0]),
        .out_freq_zero(stv[1]), .main_circuit_stable(stv[2]), .ready_state(stv[3]),
        .fault_active(stv[4]), .fault_continue_action(stv[5]), .fault_is_undervoltage(stv[16]),
        .undervoltage(stv[6]), .frequency_level_detect_one(stv[7]), .frequency_level_detect_two(stv[8]),
        .freq_reached(stv[9]), .freq1_reached(stv[10]), .freq2_reached(stv[11]),
        .upper_limit_reached(stv[12]), .lower_limit_reached(stv[13]), .current1_reached(stv[14]),
        .current2_reached(stv[15]), .first_output_terminal(first), .relay_output(relay)
    );

    terminal_reader reader (.clk(clk), .rst_b(rst_b), .pin(first), .half_q(half));

    // ----------------------------------------
    // compare, bus and terminal tasks
    // ----------------------------------------
    task cmp_word(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: word %h, expected %h", $time, got, exp);
        end
    endtask

    task cmp_bit(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: terminal %b, expected %b", $time, got, exp);
        end
    endtask

    // both channels offered together, each dropped at its own handshake
    task axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!(bvalid && bready) && n < 200);
        bready <= 1'b0;
        if (n == 200) failures++;
        cmp_word({30'h0, bresp}, {30'h0, er});
    endtask

    task axi_read(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!(rvalid && rready) && n < 200);
        rready <= 1'b0;
        if (n == 200) failures++;
        cmp_word(rdata, ed);
        cmp_word({30'h0, rresp}, {30'h0, er});
    endtask

    // apply a status set, let the registered terminals settle
    task chk_term(input logic [16:0] v, input logic ef, input logic er);
        @(posedge clk);
        stv <= v;
        repeat (3) @(posedge clk);
        cmp_bit(first, ef);
        cmp_bit(relay, er);
    endtask

    task give_verdict;
        $display("checked %0d, failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // test sequence
    // ----------------------------------------
    initial begin
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        axi_read(8'h00, 32'h1, `RESP_OKAY);
        axi_read(8'h04, 32'h0, `RESP_OKAY);
        axi_read(8'h08, 32'h0, `RESP_OKAY);
        axi_read(8'h14, 32'h0, `RESP_SLVERR);
        axi_write(8'h10, 32'h7, `RESP_SLVERR);
        axi_write(8'h08, 32'hABCD0006, `RESP_OKAY);
        axi_read(8'h08, 32'h6, `RESP_OKAY);
        // codes 0..19, 42 and FFFF, each under two status sets, in switch mode; only 1..18 assert
        for (i = 0; i < 22; i++) begin
            axi_write(8'h04, {16'h0, codes[i]}, `RESP_OKAY);
            axi_write(8'h08, {16'h0, codes[i]}, `RESP_OKAY);
            chk_term(v_on[i], e_on[i], e_on[i]);
            chk_term(v_off[i], 1'b0, 1'b0);
        end
        // the two codes act independently
        axi_write(8'h04, 32'h1, `RESP_OKAY);
        axi_write(8'h08, 32'h6, `RESP_OKAY);
        chk_term(17'h00001, 1'b1, 1'b0);
        chk_term(17'h00040, 1'b0, 1'b1);
        // pulse mode: too short a half period is clamped
        @(posedge clk);
        stv <= 17'h00001;
        axi_write(8'h0C, 32'hA, `RESP_OKAY);
        axi_write(8'h00, 32'h0, `RESP_OKAY);
        repeat (700) @(posedge clk);
        cmp_word(half, 32'd100);
        axi_write(8'h0C, 32'hC8, `RESP_OKAY);
        repeat (1000) @(posedge clk);
        cmp_word(half, 32'd200);
        // back to switch mode, the code rules again
        axi_write(8'h00, 32'h1, `RESP_OKAY);
        chk_term(17'h00001, 1'b1, 1'b0);
        axi_read(8'h10, 32'h1, `RESP_OKAY);
        give_verdict;
    end

    // cut a hang short
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        give_verdict;
    end
endmodule // output_terminal_function_select_tb_top
